// ### src/mgs_pkg.sv
// Overview of operation
// - Each pad: input, output, alternate function or alarm
// - Input pad read returns live pad level
// - Output pad level writable and read back
// - Alternate pads follow engine, ignore user settings
// - Output pads drive both levels, push-pull
// - Low on transmit-control pad disables transmitter
// - Monitor high while transmitter active, then low
// - Monitor leads 300 ms, lags 500-1000 ms
// - Alarm pad high at alarm, low on clear
// - Buzzer pad outputs square wave tones
// - Indicator pin is inverse of lamp state
// - Search/unregistered: 1 s period, 0.5 s on
// - Registered: 3 s period, 0.3 s on
// - Device off: lamp off; call: lamp on
package mgs_pkg;

    // ------------------------------------------------------------
    // Sizes and pad positions
    // ------------------------------------------------------------
    localparam int NUM_PADS    = 9;
    localparam int TXMON_IDX   = 2;
    localparam int BUZZ_IDX    = 3;
    localparam int TXCTL_IDX   = 6;
    localparam int ADDR_W      = 6;
    localparam int MS_W        = 12;
    localparam int BUZZ_W      = 16;
    localparam int TICK_CNT_W  = 16;
    localparam int NUM_IRQ     = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int MS_NS          = 1000000;
    localparam int MS_CYCLES_DEF  = MS_NS / CLK_PERIOD_NS;
    localparam logic [MS_W-1:0] TX_LEAD_MS    = 12'd300;
    localparam logic [MS_W-1:0] TX_LAG_MIN_MS = 12'd500;
    localparam logic [MS_W-1:0] TX_LAG_MAX_MS = 12'd1000;
    localparam logic [MS_W-1:0] TX_LAG_MS     =
        MS_W'((TX_LAG_MIN_MS + TX_LAG_MAX_MS) >> 1);
    localparam logic [MS_W-1:0] FAST_PERIOD_MS = 12'd1000;
    localparam logic [MS_W-1:0] FAST_ON_MS     = 12'd500;
    localparam logic [MS_W-1:0] SLOW_PERIOD_MS = 12'd3000;
    localparam logic [MS_W-1:0] SLOW_ON_MS     = 12'd300;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_MODE      = 6'h00;
    localparam logic [ADDR_W-1:0] REG_OUT       = 6'h04;
    localparam logic [ADDR_W-1:0] REG_IN        = 6'h08;
    localparam logic [ADDR_W-1:0] REG_ALARM_CLR = 6'h0c;
    localparam logic [ADDR_W-1:0] REG_BUZZ_CTRL = 6'h10;
    localparam logic [ADDR_W-1:0] REG_BUZZ_LEN  = 6'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 6'h18;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR   = 6'h1c;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN    = 6'h20;
    localparam logic [ADDR_W-1:0] REG_ENGINE    = 6'h24;

    // Field positions
    localparam int BUZZ_ON_BIT   = 0;
    localparam int BUZZ_HALF_LSB = 16;
    localparam int IRQ_ALARM     = 0;
    localparam int IRQ_TXDIS     = 1;
    localparam int IRQ_TXEND     = 2;
    localparam int ENG_TXMON     = 0;
    localparam int ENG_TXDIS     = 1;
    localparam int ENG_ALARM     = 2;
    localparam int ENG_LED       = 3;
    localparam int ENG_GRANT     = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       LED_PIN_RST = 1'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_IN    = 2'b00,
        PM_OUT   = 2'b01,
        PM_ALT   = 2'b10,
        PM_ALARM = 2'b11
    } mgs_pad_mode_e;

    typedef enum logic [1:0] {
        NS_OFF    = 2'b00,
        NS_SEARCH = 2'b01,
        NS_REG    = 2'b10,
        NS_CALL   = 2'b11
    } mgs_net_e;

    typedef enum logic [1:0] {
        TXM_IDLE   = 2'b00,
        TXM_LEAD   = 2'b01,
        TXM_ACTIVE = 2'b10,
        TXM_LAG    = 2'b11
    } mgs_txm_e;

    typedef struct packed {
        logic     tx_req;
        logic     tx_burst;
        logic     alarm_due;
        logic     tone_event;
        mgs_net_e net_state;
    } mgs_eng_in_s;

    typedef struct packed {
        logic tx_grant;
        logic tx_disable;
    } mgs_eng_out_s;

    typedef struct packed {
        logic [NUM_PADS-1:0] out;
        logic [NUM_PADS-1:0] oe;
    } mgs_pad_drv_s;

endpackage

// ### src/mgs_ms_tick.sv
`timescale 1ns/1ps
module mgs_ms_tick
    import mgs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock, reset and enable
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // Tick
    output logic      ms_tick
);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] cnt;
        logic                  tick;
    } mgs_tick_s;

    localparam logic [TICK_CNT_W-1:0] LAST =
        TICK_CNT_W'(MS_CYCLES - 1);

    mgs_tick_s q;
    mgs_tick_s d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt >= LAST) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign ms_tick = q.tick;

endmodule

// ### src/mgs_gpio_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mgs_gpio_top
    import mgs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock, reset, enable
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                ce,
    // AXI4-Lite write address
    input  wire logic                axi_awvalid,
    output logic                     axi_awready,
    input  wire logic [ADDR_W-1:0]   axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                axi_wvalid,
    output logic                     axi_wready,
    input  wire logic [31:0]         axi_wdata,
    input  wire logic [3:0]          axi_wstrb,
    // AXI4-Lite write response
    output logic                     axi_bvalid,
    input  wire logic                axi_bready,
    output logic [1:0]               axi_bresp,
    // AXI4-Lite read
    input  wire logic                axi_arvalid,
    output logic                     axi_arready,
    input  wire logic [ADDR_W-1:0]   axi_araddr,
    output logic                     axi_rvalid,
    input  wire logic                axi_rready,
    output logic [31:0]              axi_rdata,
    output logic [1:0]               axi_rresp,
    // Pads
    input  wire logic [NUM_PADS-1:0] pad_in,
    output mgs_pad_drv_s             pad_drv,
    // Engine side
    input  wire mgs_eng_in_s         eng_in,
    output mgs_eng_out_s             eng_out,
    // Indicator and interrupt
    output logic                     network_status_indicator,
    output logic                     irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mgs_pad_mode_e [NUM_PADS-1:0] mode;
        logic [NUM_PADS-1:0]          out_lvl;
        mgs_pad_drv_s                 drv;
        logic                         alarm;
        mgs_txm_e                     txm;
        logic [MS_W-1:0]              txm_cnt;
        logic                         tx_grant;
        logic                         tx_disable;
        logic                         buzz_on;
        logic [BUZZ_W-1:0]            buzz_half;
        logic [MS_W-1:0]              buzz_len;
        logic [MS_W-1:0]              buzz_left;
        logic [BUZZ_W-1:0]            buzz_cnt;
        logic                         buzz_lvl;
        mgs_net_e                     net_prev;
        logic [MS_W-1:0]              led_phase;
        logic                         led_pin;
        logic [NUM_IRQ-1:0]           irq_stat;
        logic [NUM_IRQ-1:0]           irq_en;
        logic                         irq;
        logic                         aw_full;
        logic [ADDR_W-1:0]            aw_addr;
        logic                         w_full;
        logic [31:0]                  w_data;
        logic [3:0]                   w_strb;
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } mgs_state_s;

    mgs_state_s q;
    mgs_state_s d;
    logic       ms_tick;

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    mgs_ms_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .ms_tick (ms_tick)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        case ({a[ADDR_W-1:2], 2'b00})
            REG_MODE, REG_OUT, REG_IN, REG_ALARM_CLR, REG_BUZZ_CTRL,
            REG_BUZZ_LEN, REG_IRQ_STAT, REG_IRQ_CLR, REG_IRQ_EN,
            REG_ENGINE: return 1'b1;
            default:    return 1'b0;
        endcase
    endfunction

    function automatic logic [MS_W-1:0] blink_period(input mgs_net_e n);
        case (n)
            NS_SEARCH: return FAST_PERIOD_MS;
            NS_REG:    return SLOW_PERIOD_MS;
            default:   return FAST_PERIOD_MS;
        endcase
    endfunction

    // Lamp state, before inversion onto the pin
    function automatic logic lamp_on(input mgs_net_e        n,
                                     input logic [MS_W-1:0] ph);
        case (n)
            NS_OFF:    return 1'b0;
            NS_SEARCH: return ph < FAST_ON_MS;
            NS_REG:    return ph < SLOW_ON_MS;
            NS_CALL:   return 1'b1;
            default:   return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [31:0]         wr_word;
    logic [31:0]         rd_word;
    logic [ADDR_W-1:0]   wr_a;
    logic [ADDR_W-1:0]   rd_a;
    logic                do_write;
    logic                alarm_clr;
    logic [NUM_IRQ-1:0]  irq_clr;
    logic [NUM_IRQ-1:0]  irq_ev;
    logic [31:0]         mode_word;
    logic                buzz_act;
    logic                lamp;

    always_comb begin
        d         = q;
        alarm_clr = 1'b0;
        irq_clr   = '0;
        irq_ev    = '0;
        wr_word   = '0;
        rd_word   = '0;
        mode_word = '0;
        wr_a      = {q.aw_addr[ADDR_W-1:2], 2'b00};
        rd_a      = {axi_araddr[ADDR_W-1:2], 2'b00};
        for (int i = 0; i < NUM_PADS; i++) begin
            mode_word[2*i +: 2] = q.mode[i];
        end

        // Write channels taken in either order
        if (axi_awvalid && q.awready) begin
            d.aw_full = 1'b1;
            d.aw_addr = axi_awaddr;
        end
        if (axi_wvalid && q.wready) begin
            d.w_full = 1'b1;
            d.w_data = axi_wdata;
            d.w_strb = axi_wstrb;
        end
        if (q.bvalid && axi_bready) begin
            d.bvalid = 1'b0;
        end

        do_write = q.aw_full && q.w_full && !q.bvalid;
        if (do_write) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = reg_known(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (wr_a)
                REG_MODE: begin
                    wr_word = merge(mode_word, q.w_data, q.w_strb);
                    for (int i = 0; i < NUM_PADS; i++) begin
                        d.mode[i] = mgs_pad_mode_e'(wr_word[2*i +: 2]);
                    end
                end
                REG_OUT: begin
                    wr_word = merge(32'(q.out_lvl), q.w_data, q.w_strb);
                    d.out_lvl = wr_word[NUM_PADS-1:0];
                end
                REG_ALARM_CLR: begin
                    alarm_clr = q.w_strb[0] & q.w_data[0];
                end
                REG_BUZZ_CTRL: begin
                    wr_word = merge({q.buzz_half, 15'h0000, q.buzz_on},
                                    q.w_data, q.w_strb);
                    d.buzz_on   = wr_word[BUZZ_ON_BIT];
                    d.buzz_half = wr_word[BUZZ_HALF_LSB +: BUZZ_W];
                end
                REG_BUZZ_LEN: begin
                    wr_word = merge(32'(q.buzz_len), q.w_data, q.w_strb);
                    d.buzz_len = wr_word[MS_W-1:0];
                end
                REG_IRQ_CLR: begin
                    irq_clr = q.w_strb[0] ? q.w_data[NUM_IRQ-1:0] : '0;
                end
                REG_IRQ_EN: begin
                    wr_word = merge(32'(q.irq_en), q.w_data, q.w_strb);
                    d.irq_en = wr_word[NUM_IRQ-1:0];
                end
                default: begin
                end
            endcase
        end

        // Read channel
        if (q.rvalid && axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (axi_arvalid && q.arready) begin
            case (rd_a)
                REG_MODE: rd_word = mode_word;
                REG_OUT:  rd_word = 32'(q.out_lvl);
                REG_IN: begin
                    for (int i = 0; i < NUM_PADS; i++) begin
                        rd_word[i] = (q.mode[i] == PM_IN) & pad_in[i];
                    end
                end
                REG_BUZZ_CTRL: rd_word = {q.buzz_half, 15'h0000, q.buzz_on};
                REG_BUZZ_LEN:  rd_word = 32'(q.buzz_len);
                REG_IRQ_STAT:  rd_word = 32'(q.irq_stat);
                REG_IRQ_EN:    rd_word = 32'(q.irq_en);
                REG_ENGINE: begin
                    rd_word[ENG_TXMON] = q.txm != TXM_IDLE;
                    rd_word[ENG_TXDIS] = q.tx_disable;
                    rd_word[ENG_ALARM] = q.alarm;
                    rd_word[ENG_LED]   = q.led_pin;
                    rd_word[ENG_GRANT] = q.tx_grant;
                end
                default: rd_word = '0;
            endcase
            d.rvalid = 1'b1;
            d.rdata  = rd_word;
            d.rresp  = reg_known(axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // --------------------------------------------------------
        // Alarm: a new alarm wins over a clear in the same cycle
        // --------------------------------------------------------
        if (eng_in.alarm_due) begin
            d.alarm = 1'b1;
        end else if (alarm_clr) begin
            d.alarm = 1'b0;
        end

        // --------------------------------------------------------
        // Transmit control and monitor
        // --------------------------------------------------------
        d.tx_disable = (q.mode[TXCTL_IDX] == PM_ALT)
                     & ~pad_in[TXCTL_IDX];
        case (q.txm)
            TXM_IDLE: begin
                d.txm_cnt = '0;
                if (eng_in.tx_req) begin
                    d.txm = TXM_LEAD;
                end
            end
            TXM_LEAD: begin
                // Bursts held back until the monitor has led long enough
                if (ms_tick) begin
                    d.txm_cnt = q.txm_cnt + 1'b1;
                end
                if (ms_tick && q.txm_cnt >= TX_LEAD_MS - 1'b1) begin
                    d.txm     = TXM_ACTIVE;
                    d.txm_cnt = '0;
                end
            end
            TXM_ACTIVE: begin
                d.txm_cnt = '0;
                if (!eng_in.tx_req) begin
                    d.txm = TXM_LAG;
                end
            end
            TXM_LAG: begin
                if (eng_in.tx_req) begin
                    d.txm = TXM_ACTIVE;
                end else if (eng_in.tx_burst) begin
                    d.txm_cnt = '0;
                end else if (ms_tick) begin
                    d.txm_cnt = q.txm_cnt + 1'b1;
                    if (q.txm_cnt >= TX_LAG_MS - 1'b1) begin
                        d.txm = TXM_IDLE;
                    end
                end
            end
            default: d.txm = TXM_IDLE;
        endcase
        d.tx_grant = (d.txm == TXM_ACTIVE) && !d.tx_disable;

        // --------------------------------------------------------
        // Buzzer tone generator
        // --------------------------------------------------------
        if (eng_in.tone_event) begin
            d.buzz_left = q.buzz_len;
        end else if (ms_tick && q.buzz_left != '0) begin
            d.buzz_left = q.buzz_left - 1'b1;
        end
        buzz_act = (q.buzz_on || q.buzz_left != '0) && q.buzz_half != '0;
        if (!buzz_act) begin
            d.buzz_cnt = '0;
            d.buzz_lvl = 1'b0;
        end else if (q.buzz_cnt >= q.buzz_half - 1'b1) begin
            d.buzz_cnt = '0;
            d.buzz_lvl = ~q.buzz_lvl;
        end else begin
            d.buzz_cnt = q.buzz_cnt + 1'b1;
        end

        // --------------------------------------------------------
        // Network status indicator
        // --------------------------------------------------------
        d.net_prev = eng_in.net_state;
        if (eng_in.net_state != q.net_prev) begin
            d.led_phase = '0;
        end else if (ms_tick) begin
            if (q.led_phase >= blink_period(q.net_prev) - 1'b1) begin
                d.led_phase = '0;
            end else begin
                d.led_phase = q.led_phase + 1'b1;
            end
        end
        lamp      = lamp_on(q.net_prev, q.led_phase);
        d.led_pin = ~lamp;

        // --------------------------------------------------------
        // Pad drivers
        // --------------------------------------------------------
        for (int i = 0; i < NUM_PADS; i++) begin
            d.drv.out[i] = 1'b0;
            d.drv.oe[i]  = 1'b0;
            case (q.mode[i])
                PM_IN: begin
                end
                PM_OUT: begin
                    d.drv.out[i] = q.out_lvl[i];
                    d.drv.oe[i]  = 1'b1;
                end
                PM_ALARM: begin
                    d.drv.out[i] = q.alarm;
                    d.drv.oe[i]  = 1'b1;
                end
                PM_ALT: begin
                    // Engine owns the pad, user level is ignored
                    if (i == TXMON_IDX) begin
                        d.drv.out[i] = q.txm != TXM_IDLE;
                        d.drv.oe[i]  = 1'b1;
                    end else if (i == BUZZ_IDX) begin
                        d.drv.out[i] = q.buzz_lvl;
                        d.drv.oe[i]  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // Interrupts: an event beats a clear in the same cycle
        // --------------------------------------------------------
        irq_ev[IRQ_ALARM] = eng_in.alarm_due;
        irq_ev[IRQ_TXDIS] = d.tx_disable & ~q.tx_disable;
        irq_ev[IRQ_TXEND] = (q.txm == TXM_LAG) && (d.txm == TXM_IDLE);
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;
        d.irq      = |(d.irq_stat & d.irq_en);

        // Bus readiness follows buffer and response occupancy
        d.awready = !d.aw_full && !d.bvalid;
        d.wready  = !d.w_full && !d.bvalid;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q         <= '0;
            q.led_pin <= LED_PIN_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------
    assign axi_awready              = q.awready;
    assign axi_wready               = q.wready;
    assign axi_bvalid               = q.bvalid;
    assign axi_bresp                = q.bresp;
    assign axi_arready              = q.arready;
    assign axi_rvalid               = q.rvalid;
    assign axi_rdata                = q.rdata;
    assign axi_rresp                = q.rresp;
    assign pad_drv                  = q.drv;
    assign eng_out.tx_grant         = q.tx_grant;
    assign eng_out.tx_disable       = q.tx_disable;
    assign network_status_indicator = q.led_pin;
    assign irq                      = q.irq;

endmodule

// ### tb/mgs_gpio_chk_properties.sv
`timescale 1ns/1ps
module mgs_gpio_chk
    import mgs_pkg::*;
(
    // Clock and reset
    input wire logic                ref_clk, rst_b,
    // Bus handshakes
    input wire logic                axi_awready, axi_wready, axi_bvalid,
    input wire logic                axi_bready, axi_arvalid, axi_arready,
    input wire logic                axi_rvalid, axi_rready,
    // Pads, engine, indicator
    input wire logic [NUM_PADS-1:0] pad_in,
    input wire mgs_eng_in_s         eng_in,
    input wire mgs_eng_out_s        eng_out,
    input wire logic                network_status_indicator
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_rd_answer: assert property (axi_arvalid && axi_arready |=> axi_rvalid)
        else $error("read answer missing");
    a_ar_blocked: assert property (axi_rvalid |-> !axi_arready)
        else $error("read address accepted while busy");
    a_wr_busy: assert property (axi_bvalid |-> !axi_awready && !axi_wready)
        else $error("write accepted while busy");
    a_b_clear: assert property (axi_bvalid && axi_bready |=> !axi_bvalid)
        else $error("write response not retired");
    a_r_clear: assert property (axi_rvalid && axi_rready |=> !axi_rvalid)
        else $error("read data not retired");
    a_txdis_cause: assert property (
        $rose(eng_out.tx_disable) |-> !$past(pad_in[TXCTL_IDX]))
        else $error("transmitter disabled without request");
    a_call_lamp: assert property (
        eng_in.net_state == NS_CALL [*3] |-> !network_status_indicator)
        else $error("lamp not on during call");
    a_off_lamp: assert property (
        eng_in.net_state == NS_OFF [*3] |-> network_status_indicator)
        else $error("lamp not off when device off");
endmodule
bind mgs_gpio_top mgs_gpio_chk chk_u (.*);

// ### tb/mgs_app_model.sv
`timescale 1ns/1ps
module mgs_app_model
    import mgs_pkg::*;
(
    // Device drive and application levels
    input  wire mgs_pad_drv_s        pad_drv,
    input  wire logic [NUM_PADS-1:0] ext_lvl,
    // Resolved pad levels
    output logic [NUM_PADS-1:0]      pad_in
);
    // Host drives released pads only
    assign pad_in = (pad_drv.oe & pad_drv.out) | (~pad_drv.oe & ext_lvl);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mgs_pkg::*;
    localparam int MS = 10;
    logic ref_clk = 0, rst_b = 0, ce = 1, irq, network_status_indicator;
    logic axi_awvalid = 0, axi_wvalid = 0, axi_arvalid = 0;
    logic axi_bready = 1, axi_rready = 1, axi_awready, axi_wready;
    logic axi_bvalid, axi_arready, axi_rvalid;
    logic [ADDR_W-1:0] axi_awaddr = '0, axi_araddr = '0;
    logic [31:0] axi_wdata = '0, axi_rdata;
    logic [3:0] axi_wstrb = 4'hf;
    logic [1:0] axi_bresp, axi_rresp;
    logic [NUM_PADS-1:0] pad_in, ext_lvl = 9'h1ff;
    mgs_pad_drv_s pad_drv;
    mgs_eng_in_s eng_in = '0;
    mgs_eng_out_s eng_out;
    int miscompares = 0, tests_run = 0;
    logic [33:0] r;
    mgs_gpio_top #(.MS_CYCLES(MS)) dut_u (.*);
    mgs_app_model app_u (.*);
    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        #4ms;
        miscompares++;
        wrap_up;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic ta, tw, tv;
        axi_awaddr <= a;
        axi_wdata <= d;
        axi_awvalid <= 1;
        axi_wvalid <= 1;
        do begin
            @(negedge ref_clk);
            {ta, tw, tv} = {axi_awready, axi_wready, axi_bvalid};
            @(posedge ref_clk);
            if (ta) axi_awvalid <= 0;
            if (tw) axi_wvalid <= 0;
        end while (!tv);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [33:0] d);
        logic ta, tv;
        axi_araddr <= a;
        axi_arvalid <= 1;
        do begin
            @(negedge ref_clk);
            {ta, tv, d} = {axi_arready, axi_rvalid, axi_rresp, axi_rdata};
            @(posedge ref_clk);
            if (ta) axi_arvalid <= 0;
        end while (!tv);
    endtask
    task automatic t_pads;
        wr(REG_MODE, 32'h2321);
        wr(REG_OUT, 32'h1);
        rd(REG_OUT, r);
        chk({pad_drv.oe[0], pad_drv.out[0], r}, {2'b11, 34'h1});
        ext_lvl[1] <= 0;
        wr(REG_OUT, 32'h1fe);
        cyc(2);
        chk(pad_drv.out[0], 1'b0);
        chk({pad_drv.oe[0], pad_drv.out[2], pad_drv.oe[6]}, 3'b100);
        rd(REG_IN, r);
        chk(r, 34'h1a8);
        rd(6'h3c, r);
        chk(r, {2'h2, 32'h0});
        $display("pads done");
    endtask
    task automatic t_tx;
        ext_lvl[TXCTL_IDX] <= 0;
        cyc(3);
        chk(eng_out.tx_disable, 1'b1);
        ext_lvl[TXCTL_IDX] <= 1;
        eng_in.tx_req <= 1;
        cyc(3);
        chk({eng_out.tx_disable, pad_drv.out[TXMON_IDX]}, 2'b01);
        cyc(290 * MS);
        chk(eng_out.tx_grant, 1'b0);
        cyc(20 * MS);
        chk(eng_out.tx_grant, 1'b1);
        eng_in.tx_req <= 0;
        cyc(490 * MS);
        chk(pad_drv.out[TXMON_IDX], 1'b1);
        cyc(520 * MS);
        chk(pad_drv.out[TXMON_IDX], 1'b0);
        $display("transmit done");
    endtask
    task automatic t_alarm;
        chk(irq, 1'b0);
        wr(REG_IRQ_EN, 32'h1);
        eng_in.alarm_due <= 1;
        cyc(1);
        eng_in.alarm_due <= 0;
        rd(REG_IRQ_STAT, r);
        chk({pad_drv.out[4], irq, r}, {2'b11, 34'h7});
        wr(REG_ALARM_CLR, 32'h1);
        wr(REG_IRQ_CLR, 32'h1);
        cyc(1);
        chk({pad_drv.out[4], irq}, 2'b00);
        $display("alarm done");
    endtask
    task automatic t_buzz;
        wr(REG_MODE, 32'h23a1);
        wr(REG_BUZZ_CTRL, 32'h40001);
        cyc(7);
        chk({pad_drv.oe[3], pad_drv.out[3]}, 2'b11);
        cyc(4);
        chk(pad_drv.out[3], 1'b0);
        wr(REG_BUZZ_LEN, 32'h2);
        wr(REG_BUZZ_CTRL, 32'h40000);
        eng_in.tone_event <= 1;
        cyc(1);
        eng_in.tone_event <= 0;
        cyc(7);
        chk(pad_drv.out[3], 1'b1);
        cyc(40);
        chk(pad_drv.out[3], 1'b0);
        $display("buzz done");
    endtask
    task automatic t_led;
        chk(network_status_indicator, 1'b1);
        eng_in.net_state <= NS_CALL;
        cyc(3);
        chk(network_status_indicator, 1'b0);
        eng_in.net_state <= NS_SEARCH;
        cyc(250 * MS);
        chk(network_status_indicator, 1'b0);
        cyc(500 * MS);
        chk(network_status_indicator, 1'b1);
        eng_in.net_state <= NS_REG;
        cyc(150 * MS);
        chk(network_status_indicator, 1'b0);
        cyc(300 * MS);
        chk(network_status_indicator, 1'b1);
        cyc(2700 * MS);
        chk(network_status_indicator, 1'b0);
        $display("indicator done");
    endtask
    task automatic wrap_up;
        $display("checks %0d bad %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(2);
        rst_b <= 1;
        cyc(1);
        t_pads;
        t_tx;
        t_alarm;
        t_buzz;
        t_led;
        wrap_up;
    end
endmodule
